// File: verilog/mlpc_pkg.sv
// Constants, field layout and types for the motor lock / phase config block.
// Assumes a single 100 MHz system clock and an 8-bit register port on the same clock.
package mlpc_pkg;

    // =========================================================
    // clock and time base
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          MS_NS         = 1000000;
    localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // =========================================================
    // register offsets and reset values
    localparam logic [3:0]  FREQ_LOCK_OFS  = 4'hA;
    localparam logic [3:0]  PHASE_ADV_OFS  = 4'hB;
    localparam logic [3:0]  DLY_COMP_OFS   = 4'hC;
    localparam logic [7:0]  FREQ_LOCK_RST  = 8'h41;
    localparam logic [7:0]  PHASE_ADV_RST  = 8'h00;
    localparam logic [7:0]  DLY_COMP_RST   = 8'h00;
    // writable bits; the rest are reserved and read as zero
    localparam logic [7:0]  FREQ_LOCK_WMSK = 8'hDF;
    localparam logic [7:0]  PHASE_ADV_WMSK = 8'h07;
    localparam logic [7:0]  DLY_COMP_WMSK  = 8'h1F;

    // =========================================================
    // field positions
    localparam int          FDIV_MSB  = 7;
    localparam int          FDIV_LSB  = 6;
    localparam int          RETRY_BIT = 4;
    localparam int          TDET_MSB  = 3;
    localparam int          TDET_LSB  = 2;
    localparam int          LOPT_MSB  = 1;
    localparam int          LOPT_LSB  = 0;
    localparam int          ADV_MSB   = 2;
    localparam int          ADV_LSB   = 0;
    localparam int          DCEN_BIT  = 4;
    localparam int          DTGT_MSB  = 3;
    localparam int          DTGT_LSB  = 0;

    // =========================================================
    // lock timing in milliseconds
    localparam logic [12:0] RETRY_SHORT_MS = 13'd500;
    localparam logic [12:0] RETRY_LONG_MS  = 13'd5000;
    localparam logic [12:0] TDET0_MS       = 13'd300;
    localparam logic [12:0] TDET1_MS       = 13'd500;
    localparam logic [12:0] TDET2_MS       = 13'd1000;
    localparam logic [12:0] TDET3_MS       = 13'd5000;

    // =========================================================
    // delay compensation target: code 0 is zero, else base + code * step
    localparam int          DLY_BASE_NS = 200;
    localparam int          DLY_STEP_NS = 200;
    localparam int          DLY_MAX_NS  = 3200;
    localparam int          DLY_MAX_CYC = DLY_MAX_NS / CLK_PERIOD_NS;

    // =========================================================
    // lock fault options and lock state machine
    localparam logic [1:0]  LOPT_LATCH  = 2'h0;
    localparam logic [1:0]  LOPT_RETRY  = 2'h1;
    localparam logic [1:0]  LOPT_REPORT = 2'h2;
    localparam logic [1:0]  LOPT_IGNORE = 2'h3;

    typedef enum logic [1:0] {
        MLPC_WATCH  = 2'b00,
        MLPC_LOCKED = 2'b01,
        MLPC_RETRY  = 2'b11
    } mlpc_lock_st_t;

    // phase advance angle in degrees per code
    function automatic logic [4:0] mlpc_adv_deg(input logic [2:0] code);
        case (code)
            3'h0:    mlpc_adv_deg = 5'h00;
            3'h1:    mlpc_adv_deg = 5'h04;
            3'h2:    mlpc_adv_deg = 5'h07;
            3'h3:    mlpc_adv_deg = 5'h0B;
            3'h4:    mlpc_adv_deg = 5'h0F;
            3'h5:    mlpc_adv_deg = 5'h14;
            3'h6:    mlpc_adv_deg = 5'h19;
            default: mlpc_adv_deg = 5'h1E;
        endcase
    endfunction

endpackage

// File: verilog/mlpc_dly_comp.sv
// Per-phase driver delay compensation: tapped delay line on each PWM input.
// Assumes all inputs come from logic on CLK_SYS_IN; no synchronisers here.
`timescale 1ns/1ns
`default_nettype none
module mlpc_dly_comp
    import mlpc_pkg::*;
#(
    parameter int PHASES   = 3,
    parameter int LINE_LEN = DLY_MAX_CYC
) (
    input  wire logic              clk_in,      // system clock
    input  wire logic              rst_b_in,    // async reset, active low
    input  wire logic              en_in,       // compensation enable
    input  wire logic [3:0]        tgt_code_in, // target delay code
    input  wire logic [PHASES-1:0] pwm_in,      // raw pwm per phase
    input  wire logic [PHASES-1:0] into_in,     // 1: current into phase
    input  wire logic [8:0]        dly_src_in,  // intrinsic delay, current into phase
    input  wire logic [8:0]        dly_snk_in,  // intrinsic delay, current out of phase
    output logic      [PHASES-1:0] pwm_out      // compensated pwm
);

    // =========================================================
    // target delay in cycles
    logic [8:0] tgt_cyc;
    assign tgt_cyc = (tgt_code_in == 4'h0) ? 9'h000 :
        9'((DLY_BASE_NS + int'(tgt_code_in) * DLY_STEP_NS) / CLK_PERIOD_NS); // R12

    // =========================================================
    // one delay line per phase; extra = target minus the direction's own delay
    genvar p;
    generate
        for (p = 0; p < PHASES; p++) begin : g_ph
            logic [LINE_LEN-1:0] line_q;
            logic [8:0]          own_dly;
            logic [8:0]          extra;
            logic                out_q;
            assign own_dly = into_in[p] ? dly_src_in : dly_snk_in;
            // a driver slower than the target gets no extra delay, never negative
            assign extra = (en_in && tgt_cyc > own_dly) ? 9'(tgt_cyc - own_dly) : 9'h000; // R11 R13
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    line_q <= '0;
                    out_q  <= 1'b0;
                end else begin
                    line_q <= {line_q[LINE_LEN-2:0], pwm_in[p]};
                    out_q  <= (extra == 9'h000) ? pwm_in[p] : line_q[extra-9'h001]; // R13
                end
            end
            assign pwm_out[p] = out_q;
        end
    endgenerate

    // =========================================================
    // checks
    comp_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R11
        !en_in |=> pwm_out == $past(pwm_in))
        else $error("pwm delayed while compensation disabled");

    comp_match_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R13
        (en_in && into_in[0] && tgt_code_in == 4'h1 && dly_src_in == 9'd30 && !pwm_in[0])
        ##1 (en_in && into_in[0] && tgt_code_in == 4'h1 && dly_src_in == 9'd30 && pwm_in[0])
        [*8] |-> !pwm_out[0])
        else $error("compensated edge appeared before target delay");

endmodule // mlpc_dly_comp
`default_nettype wire

// File: verilog/mlpc_top.sv
// Motor lock, frequency output, phase advance and delay compensation config block.
// Assumes a register port driven by the serial decoder on CLK_SYS_IN; Hall pins are async.
// =========================================================
// Overview of operation
// R1: frequency output runs at commutation rate divided by 1, 2, 4 or 8.
// R2: divider field is bits 7-6 and resets to code 1.
// R3: retry wait after lock fault is 500 ms, or 5000 ms with bit set.
// R4: lock detection time is 300, 500, 1000 or 5000 ms by code.
// R5: option 0 latches the lock fault until cleared.
// R6: option 1 holds the fault then restarts after the retry time.
// R7: option 2 reports the lock but leaves the drive running.
// R8: option 3 neither reports nor acts on a lock.
// R9: lock option field is bits 1-0 and resets to automatic retry.
// R10: phase advance angle comes from a three-bit code table.
// R11: delay compensation only acts while its enable bit is set.
// R12: target delay is zero, else 0.2 us plus 0.2 us per code.
// R13: extra delay makes both current directions meet the target.
// R14: divider and lock register sits at offset Ah, reset 41h.
// R15: lock declared when no Hall transition is seen for the detect time.
`timescale 1ns/1ns
`default_nettype none
module mlpc_top
    import mlpc_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES,
    parameter int PHASES = 3
) (
    input  wire logic              CLK_SYS_IN,                  // 100 MHz system clock
    input  wire logic              RST_B_IN,                    // async reset, active low
    input  wire logic              REG_WR_IN,                   // register write strobe
    input  wire logic [3:0]        REG_ADDR_IN,                 // register offset
    input  wire logic [7:0]        REG_WDATA_IN,                // write data
    output logic      [7:0]        REG_RDATA_OUT,               // read data, one cycle late
    input  wire logic [2:0]        HALL_IN,                     // hall comparator outputs, async
    input  wire logic              DRIVE_ACTIVE_IN,             // commutation engine driving
    input  wire logic              LOCK_CLR_IN,                 // clear latched lock fault
    input  wire logic [PHASES-1:0] PWM_IN,                      // raw pwm per phase
    input  wire logic [PHASES-1:0] CUR_INTO_IN,                 // 1: current into phase
    input  wire logic [8:0]        DLY_SRC_IN,                  // intrinsic delay into phase
    input  wire logic [8:0]        DLY_SNK_IN,                  // intrinsic delay out of phase
    output logic      [PHASES-1:0] PWM_OUT,                     // compensated pwm
    output logic                   COMMUTATION_FREQ_OUTPUT_OUT, // divided commutation clock
    output logic                   LOCK_REPORT_OUT,             // lock fault reported
    output logic                   DRIVE_INHIBIT_OUT,           // drive outputs forced off
    output logic                   LOCK_RESTART_OUT,            // one-cycle restart pulse
    output logic      [4:0]        PHASE_ADVANCE_ANGLE_OUT      // advance in degrees
);

    localparam int TW = $clog2(MS_CYC);

    // =========================================================
    // configuration registers
    logic [7:0] freq_lock_q;
    logic [7:0] phase_adv_q;
    logic [7:0] dly_comp_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       wr_fl;
    logic       wr_pa;
    logic       wr_dc;

    // address decode
    assign wr_fl = REG_WR_IN && (REG_ADDR_IN == FREQ_LOCK_OFS); // R14
    assign wr_pa = REG_WR_IN && (REG_ADDR_IN == PHASE_ADV_OFS);
    assign wr_dc = REG_WR_IN && (REG_ADDR_IN == DLY_COMP_OFS);
    // unmapped offsets read as zero
    assign rdata_d = (REG_ADDR_IN == FREQ_LOCK_OFS) ? freq_lock_q :
                     (REG_ADDR_IN == PHASE_ADV_OFS) ? phase_adv_q :
                     (REG_ADDR_IN == DLY_COMP_OFS)  ? dly_comp_q  : 8'h00;

    // register storage; reserved bits masked on write so they always read zero
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            freq_lock_q <= FREQ_LOCK_RST; // R2 R9 R14
            phase_adv_q <= PHASE_ADV_RST;
            dly_comp_q  <= DLY_COMP_RST;
            rdata_q     <= 8'h00;
        end else begin
            if (wr_fl) freq_lock_q <= REG_WDATA_IN & FREQ_LOCK_WMSK;
            if (wr_pa) phase_adv_q <= REG_WDATA_IN & PHASE_ADV_WMSK;
            if (wr_dc) dly_comp_q  <= REG_WDATA_IN & DLY_COMP_WMSK;
            rdata_q <= rdata_d;
        end
    end
    assign REG_RDATA_OUT = rdata_q;

    // field extraction
    logic [1:0] fdiv;
    logic       retry_sel;
    logic [1:0] tdet_sel;
    logic [1:0] lopt;
    assign fdiv      = freq_lock_q[FDIV_MSB:FDIV_LSB]; // R2
    assign retry_sel = freq_lock_q[RETRY_BIT];
    assign tdet_sel  = freq_lock_q[TDET_MSB:TDET_LSB];
    assign lopt      = freq_lock_q[LOPT_MSB:LOPT_LSB]; // R9

    // =========================================================
    // hall synchroniser and transition detect
    logic [2:0] hall_s1_q;
    logic [2:0] hall_s2_q;
    logic [2:0] hall_prev_q;
    logic [2:0] hall_vld_q;
    logic       hall_edge;

    // two flops before anything looks at the pins
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            hall_s1_q   <= 3'h0;
            hall_s2_q   <= 3'h0;
            hall_prev_q <= 3'h0;
            hall_vld_q  <= 3'h0;
        end else begin
            hall_s1_q   <= HALL_IN;
            hall_s2_q   <= hall_s1_q;
            hall_prev_q <= hall_s2_q;
            hall_vld_q  <= {hall_vld_q[1:0], 1'b1};
        end
    end
    // held off until the pipe holds real pin samples, so reset never looks like a commutation
    assign hall_edge = hall_vld_q[2] && (hall_s2_q != hall_prev_q);

    // =========================================================
    // frequency output divider: toggles every 2^code transitions
    logic [2:0] fg_cnt_q;
    logic       fg_q;
    logic [2:0] div_last;
    assign div_last = (fdiv == 2'h0) ? 3'h0 :
                      (fdiv == 2'h1) ? 3'h1 :
                      (fdiv == 2'h2) ? 3'h3 : 3'h7; // R1

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            fg_cnt_q <= 3'h0;
            fg_q     <= 1'b0;
        end else if (hall_edge) begin
            // a divider change mid-count takes effect at once; a count already past the new limit wraps on the next transition
            if (fg_cnt_q >= div_last) begin
                fg_cnt_q <= 3'h0;
                fg_q     <= ~fg_q; // R1
            end else begin
                fg_cnt_q <= fg_cnt_q + 3'h1;
            end
        end
    end
    assign COMMUTATION_FREQ_OUTPUT_OUT = fg_q;

    // =========================================================
    // millisecond tick and lock timers
    logic [TW-1:0]  tick_cnt_q;
    logic           tick;
    logic [12:0]    ms_cnt_q;
    logic [12:0]    tdet_ms;
    logic [12:0]    retry_ms;
    mlpc_lock_st_t  st_q;
    mlpc_lock_st_t  st_d;
    logic           kind_latch_q;
    logic           restart_q;
    logic           lock_det;
    logic           tmr_clr;
    logic           leave_locked;

    assign tdet_ms  = (tdet_sel == 2'h0) ? TDET0_MS :
                      (tdet_sel == 2'h1) ? TDET1_MS :
                      (tdet_sel == 2'h2) ? TDET2_MS : TDET3_MS; // R4
    assign retry_ms = retry_sel ? RETRY_LONG_MS : RETRY_SHORT_MS; // R3
    assign tick     = (tick_cnt_q == TW'(MS_CYC - 1));

    // timer restarts on every state change, and in watch on each hall transition or idle drive
    assign tmr_clr  = (st_q != st_d) || (st_q == MLPC_WATCH && (hall_edge || !DRIVE_ACTIVE_IN));

    // lock: full detect time without a transition while driving
    assign lock_det = (st_q == MLPC_WATCH) && DRIVE_ACTIVE_IN && !hall_edge &&
                      (ms_cnt_q == tdet_ms) && (lopt != LOPT_IGNORE); // R15 R8

    // latched faults leave only on clear; report-only also leaves when the rotor moves
    assign leave_locked = LOCK_CLR_IN || (!kind_latch_q && hall_edge); // R5 R7

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            MLPC_WATCH: begin
                if (lock_det) begin
                    st_d = (lopt == LOPT_RETRY) ? MLPC_RETRY : MLPC_LOCKED; // R6
                end
            end
            MLPC_LOCKED: begin
                if (leave_locked) st_d = MLPC_WATCH;
            end
            MLPC_RETRY: begin
                if (ms_cnt_q == retry_ms) st_d = MLPC_WATCH; // R6 R3
            end
            default: st_d = MLPC_WATCH;
        endcase
    end

    // timers; counter saturates so a long stall cannot wrap past the threshold
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tick_cnt_q <= '0;
            ms_cnt_q   <= 13'h0000;
        end else if (tmr_clr) begin
            tick_cnt_q <= '0;
            ms_cnt_q   <= 13'h0000;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TW'(1);
            if (tick && ms_cnt_q != 13'h1FFF) ms_cnt_q <= ms_cnt_q + 13'h0001; // R4
        end
    end

    // state, fault kind and restart pulse
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_q         <= MLPC_WATCH;
            kind_latch_q <= 1'b0;
            restart_q    <= 1'b0;
        end else begin
            st_q      <= st_d;
            restart_q <= (st_q == MLPC_RETRY) && (st_d == MLPC_WATCH); // R6
            if (lock_det) kind_latch_q <= (lopt == LOPT_LATCH); // R5
        end
    end

    assign LOCK_REPORT_OUT   = (st_q != MLPC_WATCH); // R7
    assign DRIVE_INHIBIT_OUT = (st_q == MLPC_RETRY) || (st_q == MLPC_LOCKED && kind_latch_q); // R5 R6
    assign LOCK_RESTART_OUT  = restart_q;

    // =========================================================
    // phase advance angle, registered
    logic [4:0] adv_q;
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) adv_q <= 5'h00;
        else           adv_q <= mlpc_adv_deg(phase_adv_q[ADV_MSB:ADV_LSB]); // R10
    end
    assign PHASE_ADVANCE_ANGLE_OUT = adv_q;

    // =========================================================
    // delay compensation
    mlpc_dly_comp #(
        .PHASES   (PHASES),
        .LINE_LEN (DLY_MAX_CYC)
    ) u_dly_comp (
        .clk_in      (CLK_SYS_IN),
        .rst_b_in    (RST_B_IN),
        .en_in       (dly_comp_q[DCEN_BIT]),          // R11
        .tgt_code_in (dly_comp_q[DTGT_MSB:DTGT_LSB]), // R12
        .pwm_in      (PWM_IN),
        .into_in     (CUR_INTO_IN),
        .dly_src_in  (DLY_SRC_IN),
        .dly_snk_in  (DLY_SNK_IN),
        .pwm_out     (PWM_OUT)
    );

    // =========================================================
    // checks
    sequence s_retry_hit;
        st_q == MLPC_WATCH && lock_det && lopt == LOPT_RETRY;
    endsequence
    sequence s_retry_hold;
        st_q == MLPC_RETRY && DRIVE_INHIBIT_OUT && LOCK_REPORT_OUT;
    endsequence

    reg_reset_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R14
        $rose(RST_B_IN) |-> freq_lock_q == 8'h41 && fdiv == 2'h1 && lopt == 2'h1)
        else $error("lock register reset value wrong");

    fg_toggle_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R1
        (hall_edge && fdiv == 2'h2 && fg_cnt_q == 3'h3) |=> COMMUTATION_FREQ_OUTPUT_OUT != $past(fg_q))
        else $error("frequency output missed its divided toggle");

    fg_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R1
        (hall_edge && fdiv == 2'h1 && fg_cnt_q == 3'h0) |=> $stable(COMMUTATION_FREQ_OUTPUT_OUT))
        else $error("divide by two toggled on the wrong transition");

    detect_time_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R15
        lock_det |-> DRIVE_ACTIVE_IN && ms_cnt_q == tdet_ms && $past(tick))
        else $error("lock declared before detect time");

    retry_enter_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R6
        s_retry_hit |=> s_retry_hold)
        else $error("retry fault not entered");

    retry_time_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R3
        $rose(LOCK_RESTART_OUT) |-> $past(ms_cnt_q) == retry_ms && !DRIVE_INHIBIT_OUT)
        else $error("restart not at retry time");

    latch_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R5
        (st_q == MLPC_LOCKED && kind_latch_q && !LOCK_CLR_IN) |=> DRIVE_INHIBIT_OUT && st_q == MLPC_LOCKED)
        else $error("latched lock fault released without clear");

    report_only_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R7
        (st_q == MLPC_WATCH && lock_det && lopt == LOPT_REPORT) |=> LOCK_REPORT_OUT && !DRIVE_INHIBIT_OUT)
        else $error("report-only lock acted on the drive");

    ignore_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R8
        (st_q == MLPC_WATCH && lopt == LOPT_IGNORE) |=> !LOCK_REPORT_OUT)
        else $error("ignored lock was reported");

    advance_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // R10
        (phase_adv_q[2:0] == 3'h3) ##1 (phase_adv_q[2:0] == 3'h3) |-> PHASE_ADVANCE_ANGLE_OUT == 5'd11)
        else $error("phase advance angle wrong");

endmodule // mlpc_top
`default_nettype wire

// File: bench/mlpc_host.sv
// Host model: writes and reads the config bytes over the plain register port.
// Assumes the bench calls wr and rd from one process, clocked by the system clock.
`timescale 1ns/1ns
`default_nettype none
module mlpc_host (
    input  wire logic       clk_in,    // system clock
    input  wire logic [7:0] rdata_in,  // read data, one cycle late
    output logic            wr_out,    // write strobe
    output logic      [3:0] addr_out,  // register offset
    output logic      [7:0] wdata_out  // write data
);
    // =========================================================
    // idle bus at time zero
    initial begin
        wr_out = 1'b0;
        addr_out = 4'h0;
        wdata_out = 8'h00;
    end
    // one strobe cycle per byte; data inverted once released, never left stale
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= v;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~v;
    endtask
    // read data follows the offset by exactly one edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        @(posedge clk_in);
        @(posedge clk_in);
        d = rdata_in;
    endtask
endmodule // mlpc_host
`default_nettype wire

// File: bench/mlpc_top_tb.sv
// Self-checking bench for the motor lock / phase config block.
// Assumes MS_CYC shortened to 10 cycles, so one millisecond is 10 clocks.
`timescale 1ns/1ns
`default_nettype none
module mlpc_top_tb;
    import mlpc_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, wr, drv = 1'b0, clr = 1'b0, fout, rep, inh, rst_p, fout_p = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [2:0] hall = 3'h0, pwm = 3'h0, into = 3'h0, pwm_o;
    logic [8:0] dsrc = 9'h000, dsnk = 9'h000;
    logic [4:0] ang;
    int         n_errors = 0, total_checks = 0, tog = 0, n;
    // =========================================================
    // clock, partner and design
    always #5 clk = ~clk;
    mlpc_host host (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
    mlpc_top #(.MS_CYC(10)) dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .REG_WR_IN(wr), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .HALL_IN(hall), .DRIVE_ACTIVE_IN(drv),
        .LOCK_CLR_IN(clr), .PWM_IN(pwm), .CUR_INTO_IN(into), .DLY_SRC_IN(dsrc), .DLY_SNK_IN(dsnk),
        .PWM_OUT(pwm_o), .COMMUTATION_FREQ_OUTPUT_OUT(fout), .LOCK_REPORT_OUT(rep),
        .DRIVE_INHIBIT_OUT(inh), .LOCK_RESTART_OUT(rst_p), .PHASE_ADVANCE_ANGLE_OUT(ang));
    // count frequency output edges of either direction
    always @(posedge clk) begin
        fout_p <= fout;
        if (fout !== fout_p) tog <= tog + 1;
    end
    // =========================================================
    // compare and wait helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkr(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("CHECK FAILED at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // bounded wait: 0 inhibit, 1 report, 2 restart pulse
    task automatic wait_sig(input int sel, output int k);
        k = 0;
        while (((sel == 0) ? inh : (sel == 1) ? rep : rst_p) !== 1'b1 && k < 12000) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    // =========================================================
    // scenarios
    task automatic t_regs;
        logic [3:0] a [4] = '{4'hA, 4'hB, 4'hC, 4'h3};
        logic [7:0] r [4] = '{8'h41, 8'h00, 8'h00, 8'h00};
        logic [7:0] m [4] = '{8'hDF, 8'h07, 8'h1F, 8'h00};
        for (int i = 0; i < 4; i++) begin
            host.rd(a[i], d);
            chk(d, r[i]);
            host.wr(a[i], 8'hFF);
            host.rd(a[i], d);
            chk(d, m[i]);
        end
    endtask
    task automatic t_angle;
        logic [4:0] deg [8] = '{5'h00, 5'h04, 5'h07, 5'h0B, 5'h0F, 5'h14, 5'h19, 5'h1E};
        for (int i = 0; i < 8; i++) begin
            host.wr(4'hB, 8'(i));
            repeat (3) @(posedge clk);
            chk({3'h0, ang}, {3'h0, deg[i]});
        end
    endtask
    // sixteen hall transitions per divider code; ignore option keeps lock quiet
    task automatic t_freq;
        for (int c = 0; c < 4; c++) begin
            host.wr(4'hA, 8'(c * 64 + 3));
            repeat (10) @(posedge clk);
            tog = 0;
            repeat (16) begin
                hall <= hall + 3'h1;
                repeat (6) @(posedge clk);
            end
            repeat (8) @(posedge clk);
            chkr(tog, 16 >> c, 16 >> c);
        end
    endtask
    task automatic t_lock;
        host.wr(4'hA, 8'h01);
        drv <= 1'b1;
        wait_sig(0, n);
        chkr(n, 2990, 3010);
        chk({7'h0, rep}, 8'h01);
        wait_sig(2, n);
        chkr(n, 4990, 5012);
        chk({7'h0, inh}, 8'h00);
        host.wr(4'hA, 8'h04);
        drv <= 1'b0;
        @(posedge clk);
        drv <= 1'b1;
        wait_sig(0, n);
        chkr(n, 4990, 5010);
        repeat (6000) @(posedge clk);
        chk({6'h0, inh, rep}, 8'h03);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        drv <= 1'b0;
        repeat (4) @(posedge clk);
        chk({6'h0, inh, rep}, 8'h00);
        host.wr(4'hA, 8'h0A);
        drv <= 1'b1;
        wait_sig(1, n);
        chkr(n, 9990, 10010);
        chk({7'h0, inh}, 8'h00);
        @(posedge clk);
        hall <= hall + 3'h1;
        drv <= 1'b0;
        host.wr(4'hA, 8'h03);
        drv <= 1'b1;
        repeat (3300) @(posedge clk);
        chk({6'h0, inh, rep}, 8'h00);
        drv <= 1'b0;
    endtask
    // cycles from a pwm rise to its compensated rise; the output flop adds one to the extra delay
    task automatic t_dly(input logic [7:0] c, input logic in, input int exp);
        host.wr(4'hC, c);
        into <= {3{in}};
        pwm <= 3'h0;
        repeat (340) @(posedge clk);
        pwm <= 3'h7;
        n = 0;
        while (pwm_o[0] !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        chkr(n, exp, exp);
    endtask
    // =========================================================
    // verdict, main sequence and watchdog
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        dsrc <= 9'd30;
        dsnk <= 9'd20;
        t_regs;
        t_angle;
        t_freq;
        t_lock;
        t_dly(8'h0F, 1'b1, 1);
        t_dly(8'h11, 1'b1, 11);
        t_dly(8'h1F, 1'b0, 301);
        conclude;
    end
    initial begin
        #1000000;
        n_errors++;
        conclude;
    end
endmodule // mlpc_top_tb
`default_nettype wire
